// ==== rtl/eac_pkg.sv ====
/*
 * Constants shared by the EEPROM access controller: register map, control
 * field layout, mode encodings and timing counts.
 * Assumes a CPU-side I/O register port clocked by the 50 MHz system clock.
 */
package eac_pkg;

	// ------------------------------------------------------------
	// Register map (data-space offsets)
	// ------------------------------------------------------------
	localparam logic [7:0] EAC_CTRL_OFS    = 8'h3f;
	localparam logic [7:0] EAC_DATA_OFS    = 8'h40;
	localparam logic [7:0] EAC_ADDR_LO_OFS = 8'h41;
	localparam logic [7:0] EAC_ADDR_HI_OFS = 8'h42;
	localparam logic [7:0] EAC_IO_BASE     = 8'h20;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int EAC_BIT_READ   = 0;
	localparam int EAC_BIT_STROBE = 1;
	localparam int EAC_BIT_ARM    = 2;
	localparam int EAC_BIT_IRQEN  = 3;
	localparam int EAC_MODE_LSB   = 4;
	localparam int EAC_MODE_MSB   = 5;

	// Programming modes
	localparam logic [1:0] EAC_MODE_ATOMIC = 2'h0;
	localparam logic [1:0] EAC_MODE_ERASE  = 2'h1;
	localparam logic [1:0] EAC_MODE_WRITE  = 2'h2;
	localparam logic [1:0] EAC_MODE_RSVD   = 2'h3;

	// ------------------------------------------------------------
	// Array geometry and reset values
	// ------------------------------------------------------------
	localparam int         EAC_ADDR_W      = 11;
	localparam int         EAC_DEPTH       = 2048;
	localparam logic [7:0] EAC_ERASED      = 8'hff;
	localparam logic [7:0] EAC_DATA_RST    = 8'h00;
	localparam logic [1:0] EAC_MODE_RST    = 2'h0;
	localparam logic [10:0] EAC_ADDR_RST   = 11'h000;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam logic [2:0] EAC_ARM_CYCLES    = 3'h4;
	localparam logic [2:0] EAC_WR_STALL      = 3'h2;
	localparam logic [2:0] EAC_RD_STALL      = 3'h4;
	localparam int         EAC_ATOMIC_TIME_US = 3400;
	localparam int         EAC_SPLIT_TIME_US  = 1800;
	localparam int         EAC_ATOMIC_RC_CYCLES = 26368;
	localparam int         EAC_SPLIT_RC_CYCLES  =
		(EAC_ATOMIC_RC_CYCLES * EAC_SPLIT_TIME_US) / EAC_ATOMIC_TIME_US;

endpackage

// ==== rtl/eac_controller.sv ====
/*
 * EEPROM access controller: control, address and data registers on the CPU
 * I/O port, the 2 KB byte array, armed write sequencing timed by the RC
 * oscillator, read fetch, CPU stall and the ready interrupt request.
 * Assumes bus_* come from CPU logic on clk; rc_osc_in, global_ie and
 * selfprog_active are treated as follows: rc_osc_in is asynchronous and
 * synchronised here, the others come from logic on clk.
 */
`timescale 1ns/1ps

module eac_controller #(
	parameter logic [14:0] ATOMIC_RC_CYCLES = 15'(eac_pkg::EAC_ATOMIC_RC_CYCLES),
	parameter logic [14:0] SPLIT_RC_CYCLES  = 15'(eac_pkg::EAC_SPLIT_RC_CYCLES)
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// CPU register port
	input  wire logic [7:0] bus_addr,
	input  wire logic       bus_io,
	input  wire logic       bus_wr,
	input  wire logic       bus_rd,
	input  wire logic [7:0] bus_wdata,
	output logic      [7:0] bus_rdata,
	// CPU status and interlocks
	input  wire logic       global_ie,
	input  wire logic       selfprog_active,
	output logic            cpu_stall,
	output logic            ready_irq,
	// Calibrated RC oscillator
	input  wire logic       rc_osc_in
);
	import eac_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0]  mode;
		logic        irq_en;
		logic        arm;
		logic [2:0]  arm_cnt;
		logic        strobe;
		logic [1:0]  op;
		logic [7:0]  wr_data;
		logic [10:0] addr;
		logic [7:0]  data;
		logic [14:0] tick_cnt;
		logic        commit;
		logic [2:0]  stall_cnt;
		logic        stall;
		logic        irq;
		logic [7:0]  rdata;
		logic        rc_s1;
		logic        rc_s2;
		logic        rc_s3;
	} eac_state_t;

	eac_state_t q;
	eac_state_t d;
	logic [7:0] mem [EAC_DEPTH];
	logic [7:0] eff_addr;
	logic       wr;
	logic       rd;
	logic       rc_tick;
	logic       ctrl_wr;
	logic       wr_go;
	logic       rd_go;
	logic [7:0] commit_val;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Programming time in RC cycles for an operation
	function automatic logic [14:0] op_ticks(input logic [1:0] op);
		op_ticks = (op == EAC_MODE_ATOMIC) ? ATOMIC_RC_CYCLES : SPLIT_RC_CYCLES;
	endfunction

	// Control register image as software sees it
	function automatic logic [7:0] ctrl_image(input eac_state_t s);
		ctrl_image = {2'h0, s.mode, s.irq_en, s.arm, s.strobe, 1'b0};
	endfunction

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------

	// I/O-instruction addresses sit 0x20 below the data-space offsets
	assign eff_addr = bus_io ? 8'(bus_addr + EAC_IO_BASE) : bus_addr;
	assign wr       = bus_wr & ~reset;
	assign rd       = bus_rd & ~reset;
	assign ctrl_wr  = wr && (eff_addr == EAC_CTRL_OFS);
	assign rc_tick  = q.rc_s2 & ~q.rc_s3;

	// Start conditions; reserved mode and flash programming block a start
	assign wr_go = ctrl_wr && bus_wdata[EAC_BIT_STROBE] && q.arm && !q.strobe
		&& !selfprog_active
		&& (bus_wdata[EAC_MODE_MSB:EAC_MODE_LSB] != EAC_MODE_RSVD);
	assign rd_go = ctrl_wr && bus_wdata[EAC_BIT_READ] && !q.strobe && !wr_go;

	// Value committed to the array at the end of a write
	always_comb
	begin
		unique case (q.op)
			EAC_MODE_ERASE:  commit_val = EAC_ERASED;
			EAC_MODE_WRITE:  commit_val = mem[q.addr] & q.wr_data;
			default:         commit_val = q.wr_data;
		endcase
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		d        = q;
		d.commit = 1'b0;

		// RC oscillator crosses in through two flops, the third finds edges
		d.rc_s1 = rc_osc_in;
		d.rc_s2 = q.rc_s1;
		d.rc_s3 = q.rc_s2;

		// Arm window closes on its own after four cycles
		if (q.arm)
		begin
			if (q.arm_cnt == 3'h0)
				d.arm = 1'b0;
			else
				d.arm_cnt = q.arm_cnt - 3'h1;
		end

		// Address and data registers
		if (wr && (eff_addr == EAC_DATA_OFS))
			d.data = bus_wdata;
		if (wr && !q.strobe && (eff_addr == EAC_ADDR_LO_OFS))
			d.addr[7:0] = bus_wdata;
		if (wr && !q.strobe && (eff_addr == EAC_ADDR_HI_OFS))
			d.addr[10:8] = bus_wdata[2:0];

		// Control register writes
		if (ctrl_wr)
		begin
			d.irq_en = bus_wdata[EAC_BIT_IRQEN];
			if (!q.strobe)
				d.mode = bus_wdata[EAC_MODE_MSB:EAC_MODE_LSB];
			if (bus_wdata[EAC_BIT_ARM])
			begin
				d.arm     = 1'b1;
				d.arm_cnt = EAC_ARM_CYCLES - 3'h1;
			end
		end

		// Write start: latch operation and data, the armed window is used up
		if (wr_go)
		begin
			d.strobe    = 1'b1;
			d.op        = bus_wdata[EAC_MODE_MSB:EAC_MODE_LSB];
			d.wr_data   = q.data;
			d.tick_cnt  = 15'h0000;
			d.arm       = 1'b0;
			d.stall_cnt = EAC_WR_STALL;
		end

		// Read: data available at once, CPU held meanwhile
		if (rd_go)
		begin
			// A byte committed this cycle is forwarded, so an early read is not stale
			d.data      = q.commit ? commit_val : mem[q.addr];
			d.stall_cnt = EAC_RD_STALL;
		end

		// Programming time, counted on RC oscillator edges
		if (q.strobe && rc_tick)
		begin
			if (q.tick_cnt == op_ticks(q.op) - 15'h0001)
			begin
				d.strobe   = 1'b0;
				d.commit   = 1'b1;
				d.tick_cnt = 15'h0000;
			end
			else
				d.tick_cnt = q.tick_cnt + 15'h0001;
		end

		// Stall countdown
		if (!wr_go && !rd_go && (q.stall_cnt != 3'h0))
			d.stall_cnt = q.stall_cnt - 3'h1;

		// Register read port, one cycle latency
		d.rdata = 8'h00;
		if (rd)
		begin
			unique case (eff_addr)
				EAC_CTRL_OFS:    d.rdata = ctrl_image(q);
				EAC_DATA_OFS:    d.rdata = q.data;
				EAC_ADDR_LO_OFS: d.rdata = q.addr[7:0];
				EAC_ADDR_HI_OFS: d.rdata = {5'h00, q.addr[10:8]};
				default:         d.rdata = 8'h00;
			endcase
		end

		// Reset leaves a running write to finish, so its timing state stays;
		// idle is the else branch, so an unknown strobe at power-up still clears
		if (reset)
		begin
			d.irq_en    = 1'b0;
			d.arm       = 1'b0;
			d.arm_cnt   = 3'h0;
			d.stall_cnt = 3'h0;
			d.data      = EAC_DATA_RST;
			if (q.strobe)
				d.addr = q.addr;
			else
			begin
				d.mode     = EAC_MODE_RST;
				d.strobe   = 1'b0;
				d.tick_cnt = 15'h0000;
				d.op       = EAC_MODE_RST;
				d.addr     = EAC_ADDR_RST;
			end
		end

		// Registered outputs; interrupt held off by write or self-program
		d.stall = (d.stall_cnt != 3'h0);
		d.irq   = d.irq_en && global_ie && !d.strobe && !selfprog_active;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
		q <= d;

	// Array update at the end of the programming time
	always_ff @(posedge clk)
	begin
		if (q.commit)
			mem[q.addr] <= commit_val;
	end

	assign bus_rdata = q.rdata;
	assign cpu_stall = q.stall;
	assign ready_irq = q.irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// Arm loads a four-cycle window
	chk_arm_load: assert property ($rose(q.arm) |-> q.arm_cnt == EAC_ARM_CYCLES - 3'h1)
		else $error("arm window not loaded with four cycles");

	// Arm drops after its last cycle unless re-armed
	chk_arm_expire: assert property (
		(q.arm && q.arm_cnt == 3'h0 && !(ctrl_wr && bus_wdata[EAC_BIT_ARM])) |=> !q.arm)
		else $error("arm bit outlived its window");

	// A write only starts from an armed state, never under self-program
	chk_start_armed: assert property (
		$rose(q.strobe) |-> ($past(q.arm) && !$past(selfprog_active) && q.op != EAC_MODE_RSVD))
		else $error("write started without arm or during self-program");

	// Mode stands still while a write runs
	chk_mode_hold: assert property (q.strobe |=> $stable(q.mode))
		else $error("mode bits changed during write");

	// Address frozen during a write
	chk_busy_freeze: assert property (q.strobe |=> $stable(q.addr))
		else $error("address changed during write");

	// A read strobe during a write neither fetches nor stalls
	chk_read_refused: assert property (
		(q.strobe && q.stall_cnt == 3'h0 && ctrl_wr && bus_wdata[EAC_BIT_READ]) |=> !q.stall)
		else $error("read accepted during write");

	// Write ends only after the full RC count of its mode
	chk_write_time: assert property (
		$fell(q.strobe) |-> (q.commit && $past(q.tick_cnt) == op_ticks($past(q.op)) - 15'h0001))
		else $error("write ended at the wrong RC count");

	// Write stall lasts two cycles
	chk_stall_write: assert property (
		$rose(q.strobe) |-> q.stall ##1 q.stall ##1 !q.stall)
		else $error("write stall not two cycles");

	// Read fetches at once and stalls four cycles
	chk_stall_read: assert property (
		rd_go |=> (q.data == mem[q.addr]) ##0 q.stall[*4] ##1 !q.stall)
		else $error("read fetch or four-cycle stall wrong");

	// Interrupt only when enabled and idle
	chk_irq_gate: assert property (
		q.irq |-> (q.irq_en && !q.strobe && $past(global_ie) && !$past(selfprog_active)))
		else $error("ready interrupt raised while gated off");

	// Interrupt held while enabled and idle
	chk_irq_level: assert property (
		(q.irq_en && !q.strobe && global_ie && !selfprog_active && !ctrl_wr && !wr_go) |=> q.irq)
		else $error("ready interrupt dropped while idle");

	// Control readback layout, upper bits zero
	chk_ctrl_read: assert property (
		(rd && eff_addr == EAC_CTRL_OFS) |=> (bus_rdata == ctrl_image($past(q))))
		else $error("control readback wrong");

	// Reset clears mode when idle
	chk_mode_reset: assert property (disable iff (1'b0)
		(reset && !q.strobe) |=> q.mode == EAC_MODE_RST)
		else $error("mode not cleared by idle reset");

	cov_atomic: cover property ($fell(q.strobe) && q.op == EAC_MODE_ATOMIC);
	cov_split:  cover property ($fell(q.strobe) && q.op != EAC_MODE_ATOMIC);
	cov_read:   cover property (rd_go);
	cov_late:   cover property (ctrl_wr && bus_wdata[EAC_BIT_STROBE] && !q.arm);
	cov_reset_busy: cover property (disable iff (1'b0) reset && q.strobe);

endmodule

// ==== verification/tb.sv ====
/*
 * Self-checking bench for the EEPROM access controller: register port,
 * armed writes in atomic, erase and write modes, reads, CPU stall, refusals and ready interrupt.
 * Assumes eac_pkg and eac_controller are compiled first; short RC counts.
 */
`timescale 1ns/1ps
module tb;
	import eac_pkg::*;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic       clk             = 1'b0;
	logic       reset           = 1'b1;
	logic [7:0] bus_addr        = 8'h00;
	logic       bus_io          = 1'b0;
	logic       bus_wr          = 1'b0;
	logic       bus_rd          = 1'b0;
	logic [7:0] bus_wdata       = 8'h00;
	logic [7:0] bus_rdata;
	logic       global_ie       = 1'b0;
	logic       selfprog_active = 1'b0;
	logic       cpu_stall;
	logic       ready_irq;
	logic       rc_osc_in       = 1'b0;
	logic [7:0] v;
	int         errors          = 0;
	int         n_checks        = 0;
	int         cycles          = 0;

	// Short RC counts keep each write to a few dozen clocks
	eac_controller #(.ATOMIC_RC_CYCLES(15'd8), .SPLIT_RC_CYCLES(15'd4)) uut (
		.clk(clk), .reset(reset), .bus_addr(bus_addr), .bus_io(bus_io), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .global_ie(global_ie),
		.selfprog_active(selfprog_active), .cpu_stall(cpu_stall), .ready_irq(ready_irq),
		.rc_osc_in(rc_osc_in));

	// ------------------------------------------------------------
	// Clocks and hang guard
	// ------------------------------------------------------------
	// 50 MHz system clock; RC period picked to stay out of phase with it
	always #10 clk = ~clk;
	always #37 rc_osc_in = ~rc_osc_in;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			results();
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Requests launch at a falling edge and drop one cycle later
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge clk);
		bus_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic io, output logic [7:0] q);
		@(negedge clk);
		bus_addr = a;
		bus_io = io;
		bus_rd = 1'b1;
		@(negedge clk);
		bus_rd = 1'b0;
		bus_io = 1'b0;
		q = bus_rdata;
	endtask

	// Counts stall cycles over a window longer than any stall
	task automatic stall_count(input int exp);
		int n;
		n = 0;
		for (int i = 0; i < 8; i++)
		begin
			if (cpu_stall === 1'b1) n++;
			@(negedge clk);
		end
		chk(8'(n), 8'(exp));
	endtask

	task automatic wait_idle;
		int k;
		k = 0;
		rd(EAC_CTRL_OFS, 1'b0, v);
		while (v[1] === 1'b1 && k < 300)
		begin
			rd(EAC_CTRL_OFS, 1'b0, v);
			k++;
		end
		chk(v & 8'h02, 8'h00);
	endtask

	task automatic start_write(input logic [1:0] m, input logic [10:0] a, input logic [7:0] d);
		wr(EAC_ADDR_LO_OFS, a[7:0]);
		wr(EAC_ADDR_HI_OFS, {5'h00, a[10:8]});
		wr(EAC_DATA_OFS, d);
		wr(EAC_CTRL_OFS, 8'h04);
		wr(EAC_CTRL_OFS, {2'b00, m, 4'h2});
	endtask

	// Fetch the byte at the current address with the data register cleared first
	task automatic fetch(input logic [7:0] exp);
		wr(EAC_DATA_OFS, 8'h00);
		wr(EAC_CTRL_OFS, 8'h01);
		repeat (4) @(negedge clk);
		rd(EAC_DATA_OFS, 1'b0, v);
		chk(v, exp);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		rd(EAC_CTRL_OFS, 1'b0, v);
		chk(v, 8'h00);
		wr(EAC_CTRL_OFS, 8'hfc);
		rd(EAC_CTRL_OFS, 1'b0, v);
		chk(v, 8'h3c);
		repeat (4) @(negedge clk);
		rd(EAC_CTRL_OFS - EAC_IO_BASE, 1'b1, v);
		chk(v, 8'h38);
		rd(8'h3e, 1'b0, v);
		chk(v, 8'h00);
		wr(EAC_CTRL_OFS, 8'h00);
	endtask

	// Atomic write, then pokes that must bounce off the busy strobe
	task automatic t_write;
		start_write(EAC_MODE_ATOMIC, 11'h7ff, 8'ha5);
		stall_count(2);
		wr(EAC_CTRL_OFS, 8'h12);
		wr(EAC_ADDR_LO_OFS, 8'h00);
		wr(EAC_CTRL_OFS, 8'h03);
		stall_count(0);
		rd(EAC_CTRL_OFS, 1'b0, v);
		chk(v & 8'h32, 8'h02);
		wait_idle();
		rd(EAC_ADDR_LO_OFS, 1'b0, v);
		chk(v, 8'hff);
		rd(EAC_ADDR_HI_OFS, 1'b0, v);
		chk(v, 8'h07);
		wr(EAC_DATA_OFS, 8'h00);
		wr(EAC_CTRL_OFS, 8'h01);
		stall_count(4);
		rd(EAC_DATA_OFS, 1'b0, v);
		chk(v, 8'ha5);
	endtask

	// Erase survives a reset mid-write; write-only only clears bits
	task automatic t_modes;
		start_write(EAC_MODE_ERASE, 11'h400, 8'h3c);
		@(negedge clk);
		reset = 1'b1;
		repeat (2) @(negedge clk);
		reset = 1'b0;
		rd(EAC_CTRL_OFS, 1'b0, v);
		chk(v & 8'h32, 8'h12);
		wait_idle();
		fetch(EAC_ERASED);
		start_write(EAC_MODE_WRITE, 11'h400, 8'h3c);
		wait_idle();
		fetch(8'h3c);
		start_write(EAC_MODE_WRITE, 11'h400, 8'hc3);
		wait_idle();
		fetch(8'h00);
		start_write(EAC_MODE_ATOMIC, 11'h400, 8'h5a);
		wait_idle();
		fetch(8'h5a);
	endtask

	task automatic try_start(input logic [1:0] m, input int gap);
		wr(EAC_DATA_OFS, 8'h11);
		wr(EAC_CTRL_OFS, {2'b00, m, 4'h4});
		repeat (gap) @(negedge clk);
		wr(EAC_CTRL_OFS, {2'b00, m, 4'h2});
		rd(EAC_CTRL_OFS, 1'b0, v);
		chk(v & 8'h02, 8'h00);
	endtask

	// Late strobe, self-program interlock and reserved mode all start nothing
	task automatic t_refuse;
		try_start(EAC_MODE_ATOMIC, 4);
		selfprog_active = 1'b1;
		try_start(EAC_MODE_ATOMIC, 0);
		selfprog_active = 1'b0;
		try_start(EAC_MODE_RSVD, 0);
		fetch(8'h5a);
	endtask

	task automatic t_irq;
		global_ie = 1'b1;
		wr(EAC_CTRL_OFS, 8'h08);
		repeat (2) @(negedge clk);
		chk({7'h00, ready_irq}, 8'h01);
		global_ie = 1'b0;
		repeat (2) @(negedge clk);
		chk({7'h00, ready_irq}, 8'h00);
		global_ie = 1'b1;
		selfprog_active = 1'b1;
		repeat (2) @(negedge clk);
		chk({7'h00, ready_irq}, 8'h00);
		selfprog_active = 1'b0;
		wr(EAC_CTRL_OFS, 8'h0c);
		wr(EAC_CTRL_OFS, 8'h0a);
		@(negedge clk);
		chk({7'h00, ready_irq}, 8'h00);
		wait_idle();
		repeat (2) @(negedge clk);
		chk({7'h00, ready_irq}, 8'h01);
		wr(EAC_CTRL_OFS, 8'h00);
		repeat (2) @(negedge clk);
		chk({7'h00, ready_irq}, 8'h00);
	endtask

	// ------------------------------------------------------------
	// Verdict and main sequence
	// ------------------------------------------------------------
	task automatic results;
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		repeat (20) @(negedge clk);
		reset = 1'b0;
		t_regs();
		t_write();
		t_modes();
		t_refuse();
		t_irq();
		results();
	end
endmodule
